// File: logic/mcp_pkg.sv
// constants and types for the memory controller pin block
`default_nettype none
package mcp_pkg;
    localparam int MCP_NUM_CS = 8;
    localparam int MCP_NUM_LANES = 8;
    localparam int MCP_NUM_GPL = 6;
    localparam int MCP_ADDR_W = 32;
    localparam int MCP_PAT_LEN = 16;
    localparam int MCP_PAT_W = 4;
    localparam logic [3:0] MCP_CNT_RESET = 4'h0;
    localparam logic [7:0] MCP_LANES_OFF = 8'h00;
    localparam logic [7:0] MCP_LANES_ALL = 8'hff;
    localparam logic [7:0] MCP_CS_OFF = 8'hff;
    localparam logic [5:0] MCP_GPL_RESET = 6'h3f;
    localparam logic [1:0] MCP_SIZE_BYTE = 2'h0;
    localparam logic [1:0] MCP_SIZE_HALF = 2'h1;
    localparam logic [1:0] MCP_SIZE_WORD = 2'h2;
    localparam logic [1:0] MCP_SIZE_DWORD = 2'h3;
    localparam logic [1:0] MCP_PORT_8 = 2'h0;
    localparam logic [1:0] MCP_PORT_16 = 2'h1;
    localparam logic [1:0] MCP_PORT_32 = 2'h2;
    localparam logic [1:0] MCP_PORT_64 = 2'h3;
    localparam int MCP_A10_BIT = 10;
    localparam int MCP_BURST_LO = 3;
    localparam logic [2:0] MCP_BUF_MODE_RW = 3'h0;
    // sdram commands {ras_n, cas_n, we_n}
    localparam logic [2:0] MCP_CMD_NOP = 3'h7;
    localparam logic [2:0] MCP_CMD_ACT = 3'h3;
    localparam logic [2:0] MCP_CMD_READ = 3'h5;
    localparam logic [2:0] MCP_CMD_WRITE = 3'h4;
    localparam logic [2:0] MCP_CMD_PRE = 3'h2;
    localparam logic [2:0] MCP_CMD_REF = 3'h1;
    typedef enum logic [1:0] {MCP_MACH_SIMPLE_CHIP_SELECT_MACHINE, MCP_MACH_SDRAM, MCP_MACH_UPM} mcp_mach_t;
    typedef enum {MCP_S_IDLE, MCP_S_SIMPLE_CHIP_SELECT_MACHINE, MCP_S_ROW, MCP_S_COL, MCP_S_PAT, MCP_S_DONE} mcp_state_t;
endpackage
`default_nettype wire

// File: logic/mcp_lane_decode.sv
// byte-lane decode from address, size and port width
`timescale 1ns/1ps
`default_nettype none
module mcp_lane_decode (
    // access
    input wire logic [2:0] addr_lo,
    input wire logic [1:0] size,
    input wire logic [1:0] port,
    // lanes, bit 0 is lane 0
    output logic [7:0] lanes
);
    import mcp_pkg::*;
    logic [7:0] span;
    logic [2:0] base;
    always_comb begin
        unique case (size)
            MCP_SIZE_BYTE: span = 8'h01;
            MCP_SIZE_HALF: span = 8'h03;
            MCP_SIZE_WORD: span = 8'h0f;
            default: span = 8'hff;
        endcase
        // narrow ports always use the low lanes
        unique case (port)
            MCP_PORT_8: begin
                base = 3'h0;
                span = 8'h01;
            end
            MCP_PORT_16: base = {2'h0, addr_lo[0]} & 3'h0;
            MCP_PORT_32: base = {1'b0, addr_lo[1:0]};
            default: base = addr_lo;
        endcase
        if (port == MCP_PORT_16) begin
            span = span & 8'h03;
            base = {2'h0, addr_lo[0]};
        end else if (port == MCP_PORT_32) begin
            span = span & 8'h0f;
        end
        lanes = span << base;
        if (port == MCP_PORT_16) begin
            lanes = lanes & 8'h03;
        end else if (port == MCP_PORT_32) begin
            lanes = lanes & 8'h0f;
        end
    end
endmodule
`default_nettype wire

// File: logic/mcp_mem_ctl.sv
// memory controller pin sequencer: chip-select, sdram and pattern machines
`timescale 1ns/1ps
`default_nettype none
module mcp_mem_ctl (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // access request, bank already matched upstream
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [mcp_pkg::MCP_ADDR_W-1:0] req_addr,
    input wire logic req_write,
    input wire logic [1:0] req_size,
    input wire logic [2:0] req_bank,
    input wire mcp_pkg::mcp_mach_t req_mach,
    input wire logic [1:0] req_port,
    input wire logic req_parity,
    output logic req_done,
    // configuration
    input wire logic ext_master_mode,
    input wire logic [2:0] buffer_ctl_mode_field,
    input wire logic [mcp_pkg::MCP_PAT_W-1:0] pat_last,
    input wire logic [mcp_pkg::MCP_PAT_LEN*mcp_pkg::MCP_NUM_GPL-1:0] pat_lines,
    input wire logic [mcp_pkg::MCP_PAT_LEN-1:0] pat_lane_en,
    // inputs from attached devices
    input wire logic simple_machine_term_in,
    input wire logic pattern_wait_in,
    // chip selects, active low
    output logic [7:0] chip_sel_n,
    output logic parity_chip_select_n,
    // simple machine
    output logic [7:0] lane_write_strobe_n,
    output logic read_output_enable_n,
    // sdram machine
    output logic [7:0] sdram_lane_mask,
    output logic sdram_addr_bit10_cmd,
    output logic sdram_write_strobe_n,
    output logic sdram_row_strobe_n,
    output logic sdram_col_strobe_n,
    output logic sdram_addr_mux_ctl,
    // pattern machine
    output logic [7:0] pattern_lane_select_n,
    output logic pattern_line_0,
    output logic pattern_line_1,
    output logic pattern_line_2,
    output logic pattern_line_3,
    output logic pattern_line_4,
    output logic pattern_line_5,
    // bus side
    output logic address_latch_en,
    output logic buffer_ctl_0,
    output logic buffer_ctl_1,
    output logic [1:0] burst_low_addr
);
    import mcp_pkg::*;

    mcp_state_t state_r, state_nxt;
    logic [MCP_ADDR_W-1:0] addr_r, addr_nxt;
    logic write_r, write_nxt;
    logic [2:0] bank_r, bank_nxt;
    logic parity_r, parity_nxt;
    logic [7:0] lanes_r, lanes_nxt;
    logic [3:0] pat_cnt_r, pat_cnt_nxt;
    logic [7:0] cs_n_r, cs_n_nxt;
    logic parity_chip_select_n_r, parity_chip_select_n_nxt;
    logic [7:0] pwe_n_r, pwe_n_nxt;
    logic poe_n_r, poe_n_nxt;
    logic [7:0] dqm_r, dqm_nxt;
    logic a10_r, a10_nxt;
    logic [2:0] cmd_r, cmd_nxt;
    logic amux_r, amux_nxt;
    logic [7:0] pbs_n_r, pbs_n_nxt;
    logic [5:0] gpl_r, gpl_nxt;
    logic ale_r, ale_nxt;
    logic buffer_ctl_0_r, buffer_ctl_0_nxt;
    logic buffer_ctl_1_r, buffer_ctl_1_nxt;
    logic [1:0] baddr_r, baddr_nxt;
    logic done_r, done_nxt;
    logic [7:0] lanes_dec;
    logic [5:0] pat_row;
    logic [2:0] one_hot_sel;

    mcp_lane_decode u_lanes (
        .addr_lo(req_addr[2:0]),
        .size(req_size),
        .port(req_port),
        .lanes(lanes_dec)
    );

    assign req_ready = (state_r == MCP_S_IDLE);
    assign pat_row = pat_lines[pat_cnt_r*MCP_NUM_GPL +: MCP_NUM_GPL];
    assign one_hot_sel = bank_r;

    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        write_nxt = write_r;
        bank_nxt = bank_r;
        parity_nxt = parity_r;
        lanes_nxt = lanes_r;
        pat_cnt_nxt = pat_cnt_r;
        cs_n_nxt = MCP_CS_OFF;
        parity_chip_select_n_nxt = 1'b1;
        pwe_n_nxt = ~MCP_LANES_OFF;
        poe_n_nxt = 1'b1;
        dqm_nxt = MCP_LANES_ALL;
        a10_nxt = 1'b0;
        cmd_nxt = MCP_CMD_NOP;
        amux_nxt = 1'b0;
        pbs_n_nxt = ~MCP_LANES_OFF;
        gpl_nxt = gpl_r;
        ale_nxt = 1'b0;
        baddr_nxt = baddr_r;
        done_nxt = 1'b0;
        unique case (state_r)
            MCP_S_IDLE: begin
                if (req_valid) begin
                    addr_nxt = req_addr;
                    write_nxt = req_write;
                    bank_nxt = req_bank;
                    parity_nxt = req_parity;
                    lanes_nxt = lanes_dec;
                    pat_cnt_nxt = MCP_CNT_RESET;
                    // latch the address for external masters first
                    ale_nxt = ext_master_mode;
                    baddr_nxt = req_addr[MCP_BURST_LO+1:MCP_BURST_LO];
                    unique case (req_mach)
                        MCP_MACH_SIMPLE_CHIP_SELECT_MACHINE: state_nxt = MCP_S_SIMPLE_CHIP_SELECT_MACHINE;
                        MCP_MACH_SDRAM: state_nxt = MCP_S_ROW;
                        default: state_nxt = MCP_S_PAT;
                    endcase
                end
            end
            MCP_S_SIMPLE_CHIP_SELECT_MACHINE: begin
                // only the selected bank's line goes low
                cs_n_nxt = ~(8'h01 << one_hot_sel);
                parity_chip_select_n_nxt = ~parity_r;
                pwe_n_nxt = write_r ? ~lanes_r : ~MCP_LANES_OFF;
                poe_n_nxt = write_r;
                // term input is active low, pulled up when idle
                if (!simple_machine_term_in) begin
                    state_nxt = MCP_S_DONE;
                end
            end
            MCP_S_ROW: begin
                cs_n_nxt = ~(8'h01 << one_hot_sel);
                cmd_nxt = MCP_CMD_ACT;
                a10_nxt = addr_r[MCP_A10_BIT];
                amux_nxt = 1'b0;
                state_nxt = MCP_S_COL;
            end
            MCP_S_COL: begin
                cs_n_nxt = ~(8'h01 << one_hot_sel);
                cmd_nxt = write_r ? MCP_CMD_WRITE : MCP_CMD_READ;
                a10_nxt = 1'b1; // auto precharge
                amux_nxt = ext_master_mode;
                dqm_nxt = ~lanes_r;
                parity_chip_select_n_nxt = ~parity_r;
                state_nxt = MCP_S_DONE;
            end
            MCP_S_PAT: begin
                cs_n_nxt = ~(8'h01 << one_hot_sel);
                parity_chip_select_n_nxt = ~parity_r;
                pbs_n_nxt = pat_lane_en[pat_cnt_r] ? ~lanes_r : ~MCP_LANES_OFF;
                gpl_nxt = pat_row;
                // hold the pattern step frozen while the device asks to wait
                if (!pattern_wait_in) begin
                    if (pat_cnt_r == pat_last) begin
                        state_nxt = MCP_S_DONE;
                    end else begin
                        pat_cnt_nxt = pat_cnt_r + 4'h1;
                    end
                end
            end
            MCP_S_DONE: begin
                done_nxt = 1'b1;
                gpl_nxt = MCP_GPL_RESET;
                state_nxt = MCP_S_IDLE;
            end
        endcase
    end

    // buffer controls are registered from the next state, a cycle ahead of the strobes
    always_comb begin
        if (buffer_ctl_mode_field == MCP_BUF_MODE_RW) begin
            buffer_ctl_0_nxt = write_nxt & (state_nxt != MCP_S_IDLE);
            buffer_ctl_1_nxt = ~write_nxt & (state_nxt != MCP_S_IDLE);
        end else begin
            buffer_ctl_0_nxt = ~write_nxt;
            buffer_ctl_1_nxt = state_nxt != MCP_S_IDLE;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= MCP_S_IDLE;
            addr_r <= '0;
            write_r <= 1'b0;
            bank_r <= 3'h0;
            parity_r <= 1'b0;
            lanes_r <= MCP_LANES_OFF;
            pat_cnt_r <= MCP_CNT_RESET;
            cs_n_r <= MCP_CS_OFF;
            parity_chip_select_n_r <= 1'b1;
            pwe_n_r <= ~MCP_LANES_OFF;
            poe_n_r <= 1'b1;
            dqm_r <= MCP_LANES_ALL;
            a10_r <= 1'b0;
            cmd_r <= MCP_CMD_NOP;
            amux_r <= 1'b0;
            pbs_n_r <= ~MCP_LANES_OFF;
            gpl_r <= MCP_GPL_RESET;
            ale_r <= 1'b0;
            buffer_ctl_0_r <= 1'b0;
            buffer_ctl_1_r <= 1'b0;
            baddr_r <= 2'h0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            write_r <= write_nxt;
            bank_r <= bank_nxt;
            parity_r <= parity_nxt;
            lanes_r <= lanes_nxt;
            pat_cnt_r <= pat_cnt_nxt;
            cs_n_r <= cs_n_nxt;
            parity_chip_select_n_r <= parity_chip_select_n_nxt;
            pwe_n_r <= pwe_n_nxt;
            poe_n_r <= poe_n_nxt;
            dqm_r <= dqm_nxt;
            a10_r <= a10_nxt;
            cmd_r <= cmd_nxt;
            amux_r <= amux_nxt;
            pbs_n_r <= pbs_n_nxt;
            gpl_r <= gpl_nxt;
            ale_r <= ale_nxt;
            buffer_ctl_0_r <= buffer_ctl_0_nxt;
            buffer_ctl_1_r <= buffer_ctl_1_nxt;
            baddr_r <= baddr_nxt;
            done_r <= done_nxt;
        end
    end

    assign chip_sel_n = cs_n_r;
    assign parity_chip_select_n = parity_chip_select_n_r;
    assign lane_write_strobe_n = pwe_n_r;
    assign read_output_enable_n = poe_n_r;
    assign sdram_lane_mask = dqm_r;
    assign sdram_addr_bit10_cmd = a10_r;
    assign sdram_row_strobe_n = cmd_r[2];
    assign sdram_col_strobe_n = cmd_r[1];
    assign sdram_write_strobe_n = cmd_r[0];
    assign sdram_addr_mux_ctl = amux_r;
    assign pattern_lane_select_n = pbs_n_r;
    assign pattern_line_0 = gpl_r[0];
    assign pattern_line_1 = gpl_r[1];
    assign pattern_line_2 = gpl_r[2];
    assign pattern_line_3 = gpl_r[3];
    assign pattern_line_4 = gpl_r[4];
    assign pattern_line_5 = gpl_r[5];
    assign address_latch_en = ale_r;
    assign buffer_ctl_0 = buffer_ctl_0_r;
    assign buffer_ctl_1 = buffer_ctl_1_r;
    assign burst_low_addr = baddr_r;
    assign req_done = done_r;
endmodule
`default_nettype wire

// File: bench/mcp_mem_ctl_assertions.sv
// concurrent checks on the memory controller pins
`timescale 1ns/1ps
`default_nettype none
module mcp_mem_ctl_assertions (
    // clock, reset, request
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [31:0] req_addr,
    input wire logic req_done,
    // configuration and device input
    input wire logic ext_master_mode,
    input wire logic simple_machine_term_in,
    // controller pins
    input wire logic [7:0] chip_sel_n,
    input wire logic read_output_enable_n,
    input wire logic sdram_addr_bit10_cmd,
    input wire logic sdram_write_strobe_n,
    input wire logic sdram_row_strobe_n,
    input wire logic sdram_col_strobe_n,
    input wire logic sdram_addr_mux_ctl,
    input wire logic address_latch_en,
    input wire logic [1:0] burst_low_addr
);
    import mcp_pkg::*;
    logic [2:0] cmd;
    logic is_col;
    logic [1:0] addr_43;
    assign cmd = {sdram_row_strobe_n, sdram_col_strobe_n, sdram_write_strobe_n};
    assign is_col = (cmd == MCP_CMD_READ) || (cmd == MCP_CMD_WRITE);
    assign addr_43 = req_addr[4:3];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // bank decode is upstream, so overlap would be a sequencer fault
    AST_ONE_CS: assert property ($countones(~chip_sel_n) <= 1)
        else $error("two chip selects active");
    AST_IDLE_CS: assert property (req_ready |-> chip_sel_n == MCP_CS_OFF)
        else $error("chip select active while idle");
    AST_ACT_COL: assert property (cmd == MCP_CMD_ACT |=> is_col ##1 req_done)
        else $error("activate not followed by column command and done");
    AST_A10: assert property (is_col |-> sdram_addr_bit10_cmd)
        else $error("a10 low with column command");
    AST_MUX: assert property (is_col |-> sdram_addr_mux_ctl == ext_master_mode)
        else $error("address mux wrong on column command");
    AST_TERM: assert property (!read_output_enable_n && !simple_machine_term_in |-> ##[1:3] req_done)
        else $error("termination did not end the transfer");
    AST_BADDR: assert property (req_valid && req_ready |=> burst_low_addr == $past(addr_43))
        else $error("burst address bits wrong after take");
    AST_ALE: assert property (req_valid && req_ready |=> address_latch_en == $past(ext_master_mode))
        else $error("address latch enable wrong after take");
endmodule
bind mcp_mem_ctl mcp_mem_ctl_assertions mcp_mem_ctl_assertions_i (
    .ref_clk, .rst, .req_valid, .req_ready, .req_addr, .req_done, .ext_master_mode,
    .simple_machine_term_in, .chip_sel_n, .read_output_enable_n, .sdram_addr_bit10_cmd,
    .sdram_write_strobe_n, .sdram_row_strobe_n, .sdram_col_strobe_n, .sdram_addr_mux_ctl,
    .address_latch_en, .burst_low_addr);
`default_nettype wire

// File: bench/mcp_ext_dev.sv
// behavioural model of the attached memories and peripherals
`timescale 1ns/1ps
`default_nettype none
module mcp_ext_dev (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // observed controller pins
    input wire logic read_output_enable_n,
    input wire logic [7:0] lane_write_strobe_n,
    input wire logic [7:0] pattern_lane_select_n,
    // bench controls
    input wire logic [3:0] term_dly,
    input wire logic [3:0] wait_len,
    // answers
    output logic simple_machine_term_in,
    output logic pattern_wait_in
);
    logic [3:0] tcnt_r, wcnt_r;
    logic simple_act, pat_act;
    assign simple_act = !read_output_enable_n || (lane_write_strobe_n != 8'hff);
    assign pat_act = pattern_lane_select_n != 8'hff;
    // released line falls back to the pull-up, never a stale low
    assign simple_machine_term_in = !(simple_act && tcnt_r >= term_dly);
    assign pattern_wait_in = pat_act && (wcnt_r < wait_len);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tcnt_r <= 4'h0;
            wcnt_r <= 4'h0;
        end else begin
            tcnt_r <= !simple_act ? 4'h0 : tcnt_r + 4'(tcnt_r != 4'hf);
            wcnt_r <= !pat_act ? 4'h0 : wcnt_r + 4'(pattern_wait_in);
        end
    end
endmodule
`default_nettype wire

// File: bench/test_memory_controller_pins.sv
// self-checking bench for the memory controller pin block
`timescale 1ns/1ps
`default_nettype none
module test_memory_controller_pins;
    import mcp_pkg::*;
    logic ref_clk, rst, req_valid, req_ready, req_write, req_parity, req_done, ext_master_mode;
    logic [31:0] req_addr;
    logic [1:0] req_size, req_port, burst_low_addr;
    logic [2:0] req_bank, buffer_ctl_mode_field, cmd;
    mcp_mach_t req_mach;
    logic [3:0] pat_last, term_dly, wait_len;
    logic [95:0] pat_lines;
    logic [15:0] pat_lane_en;
    logic simple_machine_term_in, pattern_wait_in, parity_chip_select_n, read_output_enable_n;
    logic sdram_addr_bit10_cmd, sdram_write_strobe_n, sdram_row_strobe_n, sdram_col_strobe_n;
    logic sdram_addr_mux_ctl, address_latch_en, buffer_ctl_0, buffer_ctl_1;
    logic pattern_line_0, pattern_line_1, pattern_line_2, pattern_line_3;
    logic pattern_line_4, pattern_line_5;
    logic [7:0] chip_sel_n, lane_write_strobe_n, sdram_lane_mask, pattern_lane_select_n;
    int error_cnt, samples_checked;
    assign cmd = {sdram_row_strobe_n, sdram_col_strobe_n, sdram_write_strobe_n};

    mcp_mem_ctl mcp_mem_ctl_i (
        .ref_clk, .rst, .req_valid, .req_ready, .req_addr, .req_write, .req_size, .req_bank,
        .req_mach, .req_port, .req_parity, .req_done, .ext_master_mode, .buffer_ctl_mode_field,
        .pat_last, .pat_lines, .pat_lane_en, .simple_machine_term_in, .pattern_wait_in,
        .chip_sel_n, .parity_chip_select_n, .lane_write_strobe_n, .read_output_enable_n,
        .sdram_lane_mask, .sdram_addr_bit10_cmd, .sdram_write_strobe_n, .sdram_row_strobe_n,
        .sdram_col_strobe_n, .sdram_addr_mux_ctl, .pattern_lane_select_n, .pattern_line_0,
        .pattern_line_1, .pattern_line_2, .pattern_line_3, .pattern_line_4, .pattern_line_5,
        .address_latch_en, .buffer_ctl_0, .buffer_ctl_1, .burst_low_addr);
    mcp_ext_dev mcp_ext_dev_i (
        .ref_clk, .rst, .read_output_enable_n, .lane_write_strobe_n, .pattern_lane_select_n,
        .term_dly, .wait_len, .simple_machine_term_in, .pattern_wait_in);

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // aligned accesses only, so the span never leaves the port
    function automatic logic [7:0] exp_lanes(input logic [2:0] a, input logic [1:0] sz, pt);
        int pb;
        pb = 1 << pt;
        return 8'(((2 ** (1 << sz) - 1) << (a & (pb - 1))) & (2 ** pb - 1));
    endfunction

    // idle lines are all ones, so an and over the access sees only the steps
    function automatic logic [5:0] exp_lines(input logic [95:0] p, input logic [3:0] n);
        logic [5:0] r;
        r = 6'h3f;
        for (int k = 0; k <= n; k++) r &= p[6*k +: 6];
        return r;
    endfunction

    task automatic access(input logic [1:0] m, input logic wr);
        logic [7:0] cs_a, we_a, pbs_a, dq_o, lanes;
        logic [5:0] ln_a;
        logic oe_s, pb_s, b0_o, b1_o, act_s, col_s, a10_s, wt_p;
        int t, lat, wt;
        lanes = exp_lanes(req_addr[2:0], req_size, req_port);
        {cs_a, we_a, pbs_a, dq_o, ln_a} = {8'hff, 8'hff, 8'hff, 8'h00, 6'h3f};
        {oe_s, pb_s, b0_o, b1_o, act_s, col_s, a10_s, wt_p} = 8'h00;
        {t, lat, wt} = {32'h0, 32'h0, 32'h0};
        req_mach = mcp_mach_t'(m);
        req_write = wr;
        req_valid = 1'b1;
        // ready judged while settled, not in the edge that takes the request
        while (!req_ready && t < 50) begin
            @(negedge ref_clk);
            t++;
        end
        @(posedge ref_clk);
        @(negedge ref_clk);
        req_valid = 1'b0;
        while (req_done !== 1'b1 && lat < 200) begin
            lat++;
            cs_a &= chip_sel_n;
            we_a &= lane_write_strobe_n;
            pbs_a &= pattern_lane_select_n;
            dq_o |= ~sdram_lane_mask;
            ln_a &= {pattern_line_5, pattern_line_4, pattern_line_3, pattern_line_2,
                     pattern_line_1, pattern_line_0};
            oe_s |= !read_output_enable_n;
            pb_s |= !parity_chip_select_n;
            b0_o |= buffer_ctl_0;
            b1_o |= buffer_ctl_1;
            // last sample is the closing cycle, where wait no longer stalls
            wt += int'(wt_p);
            wt_p = pattern_wait_in;
            if (cmd == MCP_CMD_ACT) begin
                act_s = 1'b1;
                a10_s = sdram_addr_bit10_cmd;
            end
            col_s |= cmd == (wr ? MCP_CMD_WRITE : MCP_CMD_READ);
            @(negedge ref_clk);
        end
        if (t >= 50 || lat >= 200) begin
            check("timeout", 1, 0);
            print_verdict();
        end
        check("chip_sel_n", cs_a, 8'(~(8'h01 << req_bank)));
        check("parity_sel", pb_s, req_parity);
        if (m == 2'h0) check("write_strobe", we_a, wr ? 8'(~lanes) : 8'hff);
        if (m == 2'h0) check("read_oe", oe_s, !wr);
        if (m == 2'h0) check("term_len", lat, 3 + term_dly);
        if (m == 2'h1) begin
            check("lane_mask", dq_o, lanes);
            check("a10_row", a10_s, req_addr[10]);
            check("sdram_cmds", {act_s, col_s}, 2'h3);
        end
        if (m == 2'h2) begin
            check("lane_select", pbs_a, 8'(~lanes));
            check("lines", ln_a, exp_lines(pat_lines, pat_last));
            check("pattern_len", lat, pat_last + 2 + wt);
        end
        if (buffer_ctl_mode_field == MCP_BUF_MODE_RW) check("bctl", {b0_o, b1_o}, {wr, !wr});
        else check("bctl_busy", {b0_o, b1_o}, {!wr, 1'b1});
    endtask

    initial begin
        {req_valid, req_write, req_parity, ext_master_mode, rst} = 5'h01;
        {req_addr, req_size, req_port, req_bank, buffer_ctl_mode_field} = 42'h0;
        {pat_last, term_dly, wait_len, pat_lines} = 108'h0;
        req_mach = MCP_MACH_SIMPLE_CHIP_SELECT_MACHINE;
        pat_lane_en = 16'hffff;
        {error_cnt, samples_checked} = {32'h0, 32'h0};
        void'($urandom(10693));
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        // first six: widest access on narrowest and widest port, extreme delays
        for (int i = 0; i < 45; i++) begin
            req_bank = 3'($urandom);
            req_port = i < 3 ? MCP_PORT_8 : (i < 6 ? MCP_PORT_64 : 2'($urandom));
            req_size = i < 6 ? MCP_SIZE_DWORD : 2'($urandom);
            req_addr = $urandom & ~((32'h1 << req_size) - 32'h1);
            // step 0 always enabled so every pattern shows its lanes
            pat_lane_en = 16'($urandom) | 16'h0001;
            req_parity = 1'($urandom);
            ext_master_mode = 1'($urandom);
            buffer_ctl_mode_field = i < 8 ? 3'(i) : 3'($urandom);
            pat_lines = {$urandom, $urandom, $urandom};
            pat_last = i < 3 ? 4'h0 : (i < 6 ? 4'hf : 4'($urandom));
            term_dly = i < 3 ? 4'h0 : (i < 6 ? 4'h5 : 4'($urandom_range(5)));
            wait_len = i < 3 ? 4'h0 : (i < 6 ? 4'h3 : 4'($urandom_range(3)));
            access(2'(i % 3), 1'($urandom));
        end
        print_verdict();
    end
endmodule
`default_nettype wire
